// File: verilog/rx_align_consts.vh
// named constants of the receive lane alignment block
`ifndef RX_ALIGN_CONSTS_VH
`define RX_ALIGN_CONSTS_VH
`define EQ_DFE            1'b0
`define EQ_LPM            1'b1
`define BUF_HEALTH_OK     3'h0
`define BUF_HEALTH_UNDER  3'h5
`define BUF_HEALTH_OVER   3'h6
`define CC_NONE           3'h0
`define CC_REMOVED        3'h1
`define CC_INSERTED       3'h4
`define RX_ERR_NONE       3'h0
`define RX_ERR_DECODE     3'h4
`define SKP_CHAR          8'h1C
`define BOND_CHAR         8'hBC
`define BOND_WAIT_DEFAULT 4'h7
`define BOND_WAIT_ONE     4'h1
`define MIN_LAT_DEFAULT   5'h04
`define LINK_PERIOD_NS    125
`define CLK_PERIOD_NS     5
`define BOND_TIMEOUT      8'h40
`endif

// File: verilog/rx_sync2.v
// two flip-flop synchroniser for a bus of independent levels
`timescale 1ns/1ps
`default_nettype none
module rx_sync2 #(
  parameter W = 1
) (
  input  wire         ref_clk_in,
  input  wire         sys_rst_in,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      meta     <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // rx_sync2
`default_nettype wire

// File: verilog/rx_skid_buffer.v
// two-entry buffer with valid and ready on both sides, registered outputs
`timescale 1ns/1ps
`default_nettype none
module rx_skid_buffer #(
  parameter W = 9
) (
  input  wire         ref_clk_in,
  input  wire         sys_rst_in,
  input  wire [W-1:0] in_data_in,
  input  wire         in_valid_in,
  output reg          in_ready_out,
  output reg  [W-1:0] out_data_out,
  output reg          out_valid_out,
  input  wire         out_ready_in
);
  reg [W-1:0] spare;
  reg         spare_valid;
  wire        take = in_valid_in && in_ready_out;
  wire        pop  = out_valid_out && out_ready_in;

  // spare entry catches a word arriving while the output stalls
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      out_data_out  <= {W{1'b0}};
      out_valid_out <= 1'b0;
      spare         <= {W{1'b0}};
      spare_valid   <= 1'b0;
      in_ready_out  <= 1'b1;
    end else begin
      if (!out_valid_out || pop) begin
        if (spare_valid) begin
          out_data_out <= spare;
          spare_valid  <= take;
          spare        <= in_data_in;
        end else begin
          out_data_out <= in_data_in;
          out_valid_out <= take;
        end
        if (spare_valid)
          out_valid_out <= 1'b1;
      end else if (take) begin
        spare       <= in_data_in;
        spare_valid <= 1'b1;
      end
      in_ready_out <= !(spare_valid || (take && out_valid_out && !pop));
    end
  end
endmodule // rx_skid_buffer
`default_nettype wire

// File: verilog/rx_elastic_buffer_lane_bonding.v
// receive elastic buffer with clock correction and channel bonding, one lane
// Operation
// RULE_01: equaliser defaults linear; select 0 DFE, 1 linear
// RULE_02: health reports 101 underflow, 110 overflow
// RULE_03: partner sends SKP sets regularly
// RULE_04: pointer moves correct rate; count output flags it
// RULE_05: corrected SKP sets need not arrive intact
// RULE_06: master pulses trigger; slaves realign read pointer
// RULE_07: master waits programmable cycles before trigger
// RULE_08: wait setting 1..14, under half spacing
// RULE_09: wait setting resets to seven
// RULE_10: aligned flag drops when bonding lost
// RULE_11: bigger minimum latency helps heavy skew
// RULE_12: report receive errors and reference lock
// RULE_13: aligned only after all slaves adjusted
`include "rx_align_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module rx_elastic_buffer_lane_bonding #(
  parameter DEPTH      = 16,
  parameter AW         = 4,
  parameter NUM_SLAVES = 3,
  parameter HI_MARGIN  = 4
) (
  input  wire                  ref_clk_in,
  input  wire                  sys_rst_in,
  input  wire                  rx_link_clk_in,
  input  wire [7:0]            rx_link_symbol_in,
  input  wire                  rx_link_is_k_in,
  input  wire                  rx_link_code_err_in,
  input  wire                  pll_locked_in,
  input  wire                  rx_equaliser_select_in,
  input  wire                  is_master_in,
  input  wire [3:0]            bond_wait_cycles_in,
  input  wire                  bond_wait_load_in,
  input  wire [AW:0]           correction_min_latency_in,
  input  wire                  bond_trigger_in,
  input  wire [NUM_SLAVES-1:0] slave_bond_done_in,
  input  wire                  rx_ready_in,
  output reg                   equaliser_lpm_out,
  output reg  [2:0]            rx_buffer_health_out,
  output reg  [2:0]            rx_correction_count_out,
  output wire [7:0]            rx_word_out,
  output wire                  rx_control_char_flags_out,
  output wire                  rx_valid_out,
  output reg                   bond_trigger_out,
  output reg                   bond_done_out,
  output reg                   lanes_aligned_flag_out,
  output reg  [2:0]            receive_error_report_out,
  output reg                   pll_lock_out
);
  // reads pace at the nominal symbol rate; a skip at the head is dropped once, or repeated each read tick while the level stays under the minimum latency
  localparam READ_DIV = `LINK_PERIOD_NS / `CLK_PERIOD_NS;
  localparam [4:0] READ_DIV_M1 = READ_DIV[4:0] - 5'h01;
  localparam [1:0] B_IDLE = 2'h0;
  localparam [1:0] B_WAIT = 2'h1;
  localparam [1:0] B_DONE = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // link side: sample link clock and data in our own clock
  wire [11:0] link_sync;
  rx_sync2 #(.W(12)) u_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({rx_link_clk_in, rx_link_code_err_in, pll_locked_in,
                  rx_link_is_k_in, rx_link_symbol_in}),
    .sync_out   (link_sync)
  );
  wire       link_clk_s = link_sync[11];
  wire [8:0] link_word  = link_sync[8:0];
  reg        link_clk_d;
  // link data settles half a link period before the rising edge we detect
  wire       link_strobe = link_clk_s && !link_clk_d;

  ////////////////////////////////////////////////////////////////////////
  // elastic buffer storage and pointers
  reg  [8:0]  mem [0:DEPTH-1];
  reg  [AW:0] wr_ptr;
  reg  [AW:0] rd_ptr;
  reg  [4:0]  read_div;
  wire [AW:0] level = wr_ptr - rd_ptr;
  wire        empty = (level == {(AW+1){1'b0}});
  wire        full  = (level == DEPTH[AW:0]);
  wire [8:0]  head  = mem[rd_ptr[AW-1:0]];
  wire        read_tick = (read_div == 5'h00);
  wire        skid_ready;
  reg  [8:0]  emit_word;
  reg         emit_valid;

  // control character match, shared by the skip and bond decoders
  function is_ctrl;
    input [8:0] word;
    input [7:0] code;
    begin
      is_ctrl = (word == {1'b1, code});
    end
  endfunction

  // a skip at the head drives both correction branches
  wire        head_is_skp = is_ctrl(head, `SKP_CHAR);

  // offset of the first bond character between read and write pointers
  // only the nearest bond character counts; a later one waits for the next trigger
  function [AW:0] find_bond;
    input [AW:0] rp;
    input [AW:0] lv;
    integer i;
    reg [AW:0] idx;
    reg        hit;
    begin
      find_bond = {(AW+1){1'b1}};
      hit = 1'b0;
      for (i = 0; i < DEPTH; i = i + 1) begin
        idx = rp + i[AW:0];
        if (!hit && (i[AW:0] < lv) &&
            is_ctrl(mem[idx[AW-1:0]], `BOND_CHAR)) begin
          find_bond = i[AW:0];
          hit = 1'b1;
        end
      end
    end
  endfunction

  // write on every link symbol; a full buffer drops the word
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wr_ptr     <= {(AW+1){1'b0}};
      link_clk_d <= 1'b0;
    end else begin
      link_clk_d <= link_clk_s;
      if (link_strobe && !full) begin
        mem[wr_ptr[AW-1:0]] <= link_word;
        wr_ptr <= wr_ptr + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bonding wait setting and master wait state machine
  reg [3:0] bond_wait_cycles;
  reg [3:0] wait_cnt;
  reg [1:0] bstate;
  reg [7:0] bond_timer;
  reg [NUM_SLAVES-1:0] slave_bond_done_hold;
  wire      saw_bond = emit_valid && is_ctrl(emit_word, `BOND_CHAR);
  wire      all_done = &slave_bond_done_hold;
  wire [AW:0] bond_off = find_bond(rd_ptr, level);
  wire        bond_found = (bond_off != {(AW+1){1'b1}});

  // RULE_09: reset default seven
  always @(posedge ref_clk_in) begin
    if (sys_rst_in)
      bond_wait_cycles <= `BOND_WAIT_DEFAULT;
    else if (bond_wait_load_in)
      bond_wait_cycles <= bond_wait_cycles_in;
  end

  // RULE_07: wait then trigger
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      bstate               <= B_IDLE;
      wait_cnt             <= 4'h0;
      bond_trigger_out     <= 1'b0;
      bond_timer           <= 8'h00;
      slave_bond_done_hold <= {NUM_SLAVES{1'b0}};
    end else begin
      bond_trigger_out <= 1'b0;
      slave_bond_done_hold <= slave_bond_done_hold | slave_bond_done_in;
      case (bstate)
        B_IDLE: begin
          if (is_master_in && saw_bond) begin
            bstate   <= B_WAIT;
            // a zero setting is treated as the smallest legal wait
            wait_cnt <= (bond_wait_cycles == 4'h0) ? `BOND_WAIT_ONE
                                                   : bond_wait_cycles;
          end
        end
        B_WAIT: begin
          if (wait_cnt == `BOND_WAIT_ONE) begin
            // RULE_06: pulse slaves
            bond_trigger_out     <= 1'b1;
            bstate               <= B_DONE;
            bond_timer           <= `BOND_TIMEOUT;
            slave_bond_done_hold <= slave_bond_done_in;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        B_DONE: begin
          bond_timer <= bond_timer - 1'b1;
          // a slave that never answers ends the event at the timeout
          if (all_done || bond_timer == 8'h00)
            bstate <= B_IDLE;
        end
        default: bstate <= B_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read side: pacing, clock correction, slave realignment
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rd_ptr                  <= {(AW+1){1'b0}};
      read_div                <= READ_DIV_M1;
      emit_word               <= 9'h000;
      emit_valid              <= 1'b0;
      rx_buffer_health_out    <= `BUF_HEALTH_OK;
      rx_correction_count_out <= `CC_NONE;
      bond_done_out           <= 1'b0;
    end else begin
      emit_valid              <= 1'b0;
      bond_done_out           <= 1'b0;
      rx_correction_count_out <= `CC_NONE;
      read_div <= read_tick ? READ_DIV_M1 : read_div - 1'b1;
      // RULE_02: overflow report
      if (link_strobe && full)
        rx_buffer_health_out <= `BUF_HEALTH_OVER;
      else if (read_tick && skid_ready)
        rx_buffer_health_out <= empty ? `BUF_HEALTH_UNDER : `BUF_HEALTH_OK;
      if (!is_master_in && bond_trigger_in) begin
        // RULE_06: slave read realignment
        if (bond_found) begin
          rd_ptr        <= rd_ptr + bond_off;
          bond_done_out <= 1'b1;
        end
      end else if (read_tick && skid_ready && !empty) begin
        // RULE_04: pointer moves on SKP
        if (head_is_skp &&
            level > correction_min_latency_in + HI_MARGIN[AW:0]) begin
          // RULE_05: SKP removed here
          rd_ptr                  <= rd_ptr + 2'h2;
          emit_word               <= mem[rd_ptr[AW-1:0] + 1'b1];
          emit_valid              <= (level > {{AW{1'b0}}, 1'b1});
          rx_correction_count_out <= `CC_REMOVED;
        end else if (head_is_skp &&
                     level < correction_min_latency_in) begin
          // RULE_05: SKP repeated, pointer held
          emit_word               <= head;
          emit_valid              <= 1'b1;
          rx_correction_count_out <= `CC_INSERTED;
        end else begin
          rd_ptr     <= rd_ptr + 1'b1;
          emit_word  <= head;
          emit_valid <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // aligned flag, equaliser, error and lock reporting
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      lanes_aligned_flag_out <= 1'b0;
    end else if (is_master_in) begin
      // RULE_13: all slaves done
      if (bstate == B_DONE && all_done)
        lanes_aligned_flag_out <= 1'b1;
      // RULE_10: timeout drops flag
      else if (bstate == B_DONE && bond_timer == 8'h00)
        lanes_aligned_flag_out <= 1'b0;
    end else if (bond_trigger_in) begin
      // slave verdict holds until the next trigger
      // RULE_10: missing sequence is loss
      lanes_aligned_flag_out <= bond_found;
    end
  end

  // RULE_01: linear default, select
  always @(posedge ref_clk_in) begin
    if (sys_rst_in)
      equaliser_lpm_out <= `EQ_LPM;
    else
      equaliser_lpm_out <= rx_equaliser_select_in ? `EQ_LPM : `EQ_DFE;
  end

  // RULE_12: error and lock status
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      receive_error_report_out <= `RX_ERR_NONE;
      pll_lock_out             <= 1'b0;
    end else begin
      pll_lock_out <= link_sync[9];
      if (link_strobe)
        receive_error_report_out <= link_sync[10] ? `RX_ERR_DECODE
                                                  : `RX_ERR_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output buffer; a read tick that finds its ready low passes without a read
  rx_skid_buffer #(.W(9)) u_out (
    .ref_clk_in    (ref_clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_data_in    (emit_word),
    .in_valid_in   (emit_valid),
    .in_ready_out  (skid_ready),
    .out_data_out  ({rx_control_char_flags_out, rx_word_out}),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in)
  );
endmodule // rx_elastic_buffer_lane_bonding
`default_nettype wire

// File: tb/rx_align_asserts.sv
// port checker for the receive lane alignment block
`timescale 1ns/1ps
`default_nettype none
module rx_align_asserts #(parameter NUM_SLAVES = 3) (
  input wire logic                  ref_clk_in,
  input wire logic                  sys_rst_in,
  input wire logic                  rx_equaliser_select_in,
  input wire logic                  equaliser_lpm_out,
  input wire logic [2:0]            rx_buffer_health_out,
  input wire logic [2:0]            rx_correction_count_out,
  input wire logic                  pll_locked_in,
  input wire logic                  pll_lock_out,
  input wire logic                  is_master_in,
  input wire logic                  bond_trigger_in,
  input wire logic                  bond_trigger_out,
  input wire logic                  bond_done_out,
  input wire logic                  lanes_aligned_flag_out,
  input wire logic [NUM_SLAVES-1:0] slave_bond_done_in,
  input wire logic                  rx_valid_out,
  input wire logic                  rx_ready_in,
  input wire logic [7:0]            rx_word_out,
  input wire logic                  rx_control_char_flags_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////////
  eq_mode_a: assert property (
    $stable(rx_equaliser_select_in)[*3] |-> equaliser_lpm_out == rx_equaliser_select_in)
    else $error("equaliser mode differs from select");
  health_code_a: assert property (
    rx_buffer_health_out inside {3'h0, 3'h5, 3'h6}) else $error("bad health code");
  corr_pulse_a: assert property (
    rx_correction_count_out != 3'h0 |-> rx_correction_count_out inside {3'h1, 3'h4}
    ##1 rx_correction_count_out == 3'h0) else $error("bad correction pulse");
  lock_follow_a: assert property (
    $stable(pll_locked_in)[*5] |-> pll_lock_out == pll_locked_in)
    else $error("lock report differs from lock input");
  trig_pulse_a: assert property (
    bond_trigger_out |=> !bond_trigger_out[*2]) else $error("trigger pulses too close");
  slave_done_a: assert property (
    !is_master_in && $rose(bond_done_out) |-> $past(bond_trigger_in))
    else $error("slave done without trigger");
  master_align_a: assert property (
    is_master_in && $rose(lanes_aligned_flag_out)
    |-> $past(|slave_bond_done_in) || $past(|slave_bond_done_in, 2))
    else $error("master aligned without slave reports");
  word_hold_a: assert property (
    rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_word_out)
    && $stable(rx_control_char_flags_out)) else $error("stalled word changed");
endmodule // rx_align_asserts
bind rx_elastic_buffer_lane_bonding rx_align_asserts #(.NUM_SLAVES(NUM_SLAVES)) u_chk (.*);
`default_nettype wire

// File: tb/link_partner_model.sv
// behavioural link partner sending symbols with periodic compensation sets
`timescale 1ns/1ps
`default_nettype none
`include "rx_align_consts.vh"
module link_partner_model #(parameter real HALF_NS = 62.5) (
  input  wire logic       go_in,
  input  wire logic [8:0] word_in,
  output var  logic       link_clk_out,
  output var  logic [7:0] symbol_out,
  output var  logic       is_k_out
);
  int n;
  ////////////////////////////////////////////////////////////////
  // one symbol per link period; clock rests low outside frames
  initial begin
    n = 0;
    link_clk_out = 1'b0;
    {is_k_out, symbol_out} = 9'h000;
    forever begin
      if (go_in) begin
        {is_k_out, symbol_out} = (n % 8 == 7) ? {1'b1, `SKP_CHAR} : word_in;
        n++;
        #(HALF_NS) link_clk_out = 1'b1;
        #(HALF_NS) link_clk_out = 1'b0;
      end else begin
        // released lines toggle so a stale symbol never looks valid
        {is_k_out, symbol_out} = ~{is_k_out, symbol_out};
        #(HALF_NS);
      end
    end
  end
endmodule // link_partner_model
`default_nettype wire

// File: tb/rx_elastic_buffer_lane_bonding_tb_top.sv
// self-checking bench of the receive lane alignment block
`timescale 1ns/1ps
`default_nettype none
`include "rx_align_consts.vh"
module rx_elastic_buffer_lane_bonding_tb_top;
  logic        ref_clk_in, sys_rst_in, rx_link_clk_in, rx_link_is_k_in, rx_link_code_err_in;
  logic        pll_locked_in, rx_equaliser_select_in, is_master_in, bond_wait_load_in;
  logic        bond_trigger_in, rx_ready_in, equaliser_lpm_out, rx_control_char_flags_out;
  logic        rx_valid_out, bond_trigger_out, bond_done_out, lanes_aligned_flag_out;
  logic        pll_lock_out, go, bond_req, chk_on, seen_rem, seen_ins;
  logic [7:0]  rx_link_symbol_in, rx_word_out;
  logic [3:0]  bond_wait_cycles_in;
  logic [4:0]  correction_min_latency_in;
  logic [2:0]  slave_bond_done_in, rx_buffer_health_out, rx_correction_count_out;
  logic [2:0]  receive_error_report_out;
  logic [8:0]  send_word, exp_q[$];
  logic [31:0] lfsr;
  int          n_mismatch, samples_checked, cyc, t_bc, t_trg, i, d1, d7, d14;
  rx_elastic_buffer_lane_bonding u_dut (.*);
  link_partner_model u_partner (.go_in(go), .word_in(send_word), .link_clk_out(rx_link_clk_in),
    .symbol_out(rx_link_symbol_in), .is_k_out(rx_link_is_k_in));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'hA3000000 : s >> 1;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d, mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one bond event; w of zero keeps the loaded wait, dn picks the slaves that answer
  task automatic bond(input logic [3:0] w, input logic [2:0] dn, output int d);
    if (w != 4'h0) begin
      bond_wait_cycles_in = w;
      bond_wait_load_in = 1'b1;
      step(1);
      bond_wait_load_in = 1'b0;
    end
    t_trg = -1;
    t_bc = -1;
    bond_req = 1'b1;
    for (int k = 0; k < 1000 && t_trg < 0; k++) step(1);
    for (int k = 0; k < 3; k++) begin
      slave_bond_done_in = dn & (3'h1 << k);
      step(1);
    end
    slave_bond_done_in = 3'h0;
    step(70);
    cmp(9'(lanes_aligned_flag_out), 9'(dn == 3'h7), "aligned");
    for (int k = 0; k < 400 && t_bc < 0; k++) step(1);
    d = t_trg - t_bc;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  // reference model: queue of sent symbols, refilled with random data on each link edge
  always @(posedge rx_link_clk_in) begin
    if ({rx_link_is_k_in, rx_link_symbol_in} != {1'b1, `SKP_CHAR})
      exp_q.push_back({rx_link_is_k_in, rx_link_symbol_in});
    // a request stands until its character is on the line; a skip slot only delays it
    if ({rx_link_is_k_in, rx_link_symbol_in} == {1'b1, `BOND_CHAR}) bond_req = 1'b0;
    lfsr = lfsr_next(lfsr);
    send_word = bond_req ? {1'b1, `BOND_CHAR} : {1'b0, lfsr[7:0]};
  end
  // delivered words against the model; skip sets may be added or dropped
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (rx_valid_out && rx_ready_in && chk_on && {rx_control_char_flags_out, rx_word_out}
        != {1'b1, `SKP_CHAR}) cmp({rx_control_char_flags_out, rx_word_out},
        exp_q.pop_front(), "word");
    if (rx_valid_out && rx_ready_in &&
        {rx_control_char_flags_out, rx_word_out} == {1'b1, `BOND_CHAR}) t_bc = cyc;
    if (bond_trigger_out) t_trg = cyc;
    if (rx_correction_count_out == `CC_REMOVED) seen_rem = 1'b1;
    if (rx_correction_count_out == `CC_INSERTED) seen_ins = 1'b1;
  end
  // watchdog: the sequence needs about 6500 cycles
  initial begin
    #200000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    {sys_rst_in, pll_locked_in, is_master_in, rx_ready_in} = 4'hF;
    {rx_link_code_err_in, rx_equaliser_select_in, bond_wait_load_in, bond_trigger_in} = 4'h0;
    {go, bond_req, chk_on, seen_rem, seen_ins} = 5'h00;
    {n_mismatch, samples_checked, cyc} = 0;
    bond_wait_cycles_in = 4'h7;
    correction_min_latency_in = 5'h00;
    slave_bond_done_in = 3'h0;
    send_word = 9'h000;
    lfsr = 32'h93C5;
    step(10);
    cmp(9'(equaliser_lpm_out), 9'h1, "eq default");
    cmp(9'({rx_buffer_health_out, rx_correction_count_out, lanes_aligned_flag_out}), 9'h0,
        "reset outputs");
    step(6);
    sys_rst_in = 1'b0;
    for (i = 0; i < 3; i++) begin
      rx_equaliser_select_in = i[0];
      step(5);
      cmp(9'(equaliser_lpm_out), 9'(i[0]), "eq mode");
    end
    $display("test reset and equaliser done");
    go = 1'b1;
    chk_on = 1'b1;
    for (i = 0; i < 4000; i++) begin
      lfsr = lfsr_next(lfsr);
      rx_ready_in = !(i >= 500 && i < 700) && lfsr[2:0] != 3'h0;
      // more headroom in the second half
      if (i == 2000) correction_min_latency_in = 5'h08;
      rx_link_code_err_in = i >= 3000 && i < 3100;
      pll_locked_in = !(i >= 3300 && i < 3320);
      if (i == 3090) cmp(9'(receive_error_report_out), 9'(`RX_ERR_DECODE), "err");
      if (i == 3190) cmp(9'(receive_error_report_out), 9'(`RX_ERR_NONE), "err");
      if (i == 3315) cmp(9'(pll_lock_out), 9'h0, "lock");
      if (i == 3399) cmp(9'(pll_lock_out), 9'h1, "lock");
      step(1);
    end
    rx_ready_in = 1'b1;
    step(100);
    cmp(9'({seen_rem, seen_ins}), 9'h3, "corrections");
    $display("test stream done");
    bond(4'h0, 3'h7, d7);
    bond(4'h1, 3'h3, d1);
    bond(4'hE, 3'h7, d14);
    cmp(9'(d7 - d1), 9'd6, "default wait");
    cmp(9'(d14 - d1), 9'd13, "max wait");
    $display("test master bonding done");
    chk_on = 1'b0;
    rx_ready_in = 1'b0;
    for (i = 0; i < 1000 && rx_buffer_health_out !== `BUF_HEALTH_OVER; i++) step(1);
    cmp(9'(rx_buffer_health_out), 9'(`BUF_HEALTH_OVER), "overflow");
    {go, rx_ready_in} = 2'b01;
    correction_min_latency_in = 5'h00;
    for (i = 0; i < 1500 && rx_buffer_health_out !== `BUF_HEALTH_UNDER; i++) step(1);
    cmp(9'(rx_buffer_health_out), 9'(`BUF_HEALTH_UNDER), "underflow");
    $display("test buffer health done");
    // stall the reader first so the bond character stays in the buffer
    {is_master_in, go, rx_ready_in} = 3'b010;
    step(100);
    bond_req = 1'b1;
    step(200);
    bond_trigger_in = 1'b1;
    step(1);
    bond_trigger_in = 1'b0;
    cmp(9'({bond_done_out, lanes_aligned_flag_out}), 9'h3, "slave bond");
    rx_ready_in = 1'b1;
    step(300);
    bond_trigger_in = 1'b1;
    step(1);
    bond_trigger_in = 1'b0;
    cmp(9'({bond_done_out, lanes_aligned_flag_out}), 9'h0, "bond lost");
    $display("test slave bonding done");
    end_of_test;
  end
endmodule // rx_elastic_buffer_lane_bonding_tb_top
`default_nettype wire
